// ==== verilog/gt_pkg.sv ====
package gt_pkg;

    // register byte offsets
    localparam logic [7:0] GT_FIRST_CTL_OFS  = 8'h00;
    localparam logic [7:0] GT_FIRST_CNT_OFS  = 8'h04;
    localparam logic [7:0] GT_FIRST_PER_OFS  = 8'h08;
    localparam logic [7:0] GT_SECOND_CTL_OFS = 8'h0C;
    localparam logic [7:0] GT_SECOND_CNT_OFS = 8'h10;
    localparam logic [7:0] GT_SECOND_PER_OFS = 8'h14;
    localparam logic [7:0] GT_THIRD_CTL_OFS  = 8'h18;
    localparam logic [7:0] GT_THIRD_CNT_OFS  = 8'h1C;
    localparam logic [7:0] GT_THIRD_PER_OFS  = 8'h20;
    localparam logic [7:0] GT_FLAG_OFS       = 8'h24;

    // control field positions
    localparam int GT_RUN_BIT   = 15;
    localparam int GT_IDLE_BIT  = 13;
    localparam int GT_GATE_BIT  = 6;
    localparam int GT_PRE_HI    = 5;
    localparam int GT_PRE_LO    = 4;
    localparam int GT_JOIN_BIT  = 3;
    localparam int GT_SYNC_BIT  = 2;
    localparam int GT_SRC_BIT   = 1;

    // implemented control bits per timer
    localparam logic [15:0] GT_FIRST_CTL_MASK  = 16'hA076;
    localparam logic [15:0] GT_SECOND_CTL_MASK = 16'hA07A;
    localparam logic [15:0] GT_THIRD_CTL_MASK  = 16'hA072;

    // reset values
    localparam logic [15:0] GT_CTL_RST = 16'h0000;
    localparam logic [15:0] GT_CNT_RST = 16'h0000;
    localparam logic [15:0] GT_PER_RST = 16'hFFFF;

    // prescaler terminal counts (ratio minus one)
    localparam logic [7:0] GT_PRE_MAX_1   = 8'h00;
    localparam logic [7:0] GT_PRE_MAX_8   = 8'h07;
    localparam logic [7:0] GT_PRE_MAX_64  = 8'h3F;
    localparam logic [7:0] GT_PRE_MAX_256 = 8'hFF;

    typedef struct packed {
        logic       run;
        logic       halt_idle;
        logic       gate_en;
        logic [1:0] presc;
        logic       join_w;
        logic       sync;
        logic       src_ext;
    } gt_ctl_s;

endpackage : gt_pkg

// ==== verilog/gt_timers.sv ====
// Functional notes
// - first timer: 16-bit timer, synchronous or unsynchronized counter
// - first timer flags on period match, or on gate fall in gated mode
// - control bit 15 starts (1) or stops (0) the timer
// - control bit 13 set halts the timer in Idle, clear keeps it running
// - bit 6 enables gated accumulation only with internal clock selected
// - bits 5-4 prescale: 11=1:256, 10=1:64, 01=1:8, 00=1:1
// - bit 2 selects synchronized external pin; with internal clock it only shifts gate sampling
// - bit 1: 1 counts external pin rising edges, 0 counts instruction clock
// - unimplemented first control bits 14, 12-7, 3, 0 read zero
// - first timer keeps running in Idle when so configured
// - split second and third timers support all modes except unsynchronized
// - joined second and third timers form one 32-bit timer or counter
// - joined: second count is low word, third count high word
// - joined: third timer controls ignored, second's controls and pins used
// - joined: period match flags through the third timer's flag
// - joined period is third period high word, second period low word
// - joined count readable as pair, third high word, second low word
// - second, third counts are time bases; only joined pair triggers ADC
// - second control bit 3 joins the pair when 1, splits when 0
module gt_timers
    import gt_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // device state
    input  wire logic        idle_mode,
    // external clock / gate pins
    input  wire logic        first_ext_clock_pin,
    input  wire logic        second_ext_clock_pin,
    input  wire logic        third_ext_clock_pin,
    // flags and time base outputs
    output logic             first_irq_flag,
    output logic             second_irq_flag,
    output logic             third_irq_flag,
    output logic      [15:0] tb_second_count,
    output logic      [15:0] tb_third_count,
    output logic             adc_trigger
);

    function automatic gt_ctl_s gt_decode(input logic [15:0] v);
        gt_ctl_s c;
        c.run       = v[GT_RUN_BIT];
        c.halt_idle = v[GT_IDLE_BIT];
        c.gate_en   = v[GT_GATE_BIT];
        c.presc     = v[GT_PRE_HI:GT_PRE_LO];
        c.join_w    = v[GT_JOIN_BIT];
        c.sync      = v[GT_SYNC_BIT];
        c.src_ext   = v[GT_SRC_BIT];
        return c;
    endfunction : gt_decode

    function automatic logic [7:0] gt_pre_max(input logic [1:0] sel);
        logic [7:0] m;
        m = GT_PRE_MAX_1;
        case (sel)
            2'h1:    m = GT_PRE_MAX_8;
            2'h2:    m = GT_PRE_MAX_64;
            2'h3:    m = GT_PRE_MAX_256;
            default: m = GT_PRE_MAX_1;
        endcase
        return m;
    endfunction : gt_pre_max

    logic [15:0] ctl_r   [3];
    logic [15:0] cnt_r   [3];
    logic [15:0] cnt_nxt [3];
    logic [15:0] per_r   [3];
    logic [7:0]  pre_r   [3];
    logic [7:0]  pre_nxt [3];
    logic [2:0]  flag_r;
    logic [2:0]  flag_nxt;
    logic [2:0]  set_flag;
    logic [2:0]  pin_s1_r;
    logic [2:0]  pin_s2_r;
    logic [2:0]  pin_s3_r;
    logic [2:0]  prev_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        adc_r;
    logic        adc_nxt;

    gt_ctl_s     c [3];
    logic        join_w;
    logic [2:0]  lvl;
    logic [2:0]  rise;
    logic [2:0]  fall;
    logic [2:0]  gated;
    logic [2:0]  run;
    logic [2:0]  src_tick;
    logic [2:0]  pre_hit;
    logic [2:0]  match16;
    logic        match32;
    logic [31:0] cnt32;
    logic [31:0] per32;
    logic [31:0] cnt32_inc;
    logic        acc;
    logic        wr_en;
    logic [31:0] rd_data;
    logic        rd_err;
    logic [15:0] wdat;
    logic [2:0]  wr_ctl;
    logic [2:0]  wr_cnt;
    logic [2:0]  wr_per;
    logic        wr_flag;

    // apb: one wait state, write lands on the edge that samples pready
    assign acc   = psel & penable & ~pready_r;
    assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign wdat  = pwdata[15:0];

    assign wr_ctl[0] = wr_en & (paddr == GT_FIRST_CTL_OFS);
    assign wr_ctl[1] = wr_en & (paddr == GT_SECOND_CTL_OFS);
    assign wr_ctl[2] = wr_en & (paddr == GT_THIRD_CTL_OFS);
    assign wr_cnt[0] = wr_en & (paddr == GT_FIRST_CNT_OFS);
    assign wr_cnt[1] = wr_en & (paddr == GT_SECOND_CNT_OFS);
    assign wr_cnt[2] = wr_en & (paddr == GT_THIRD_CNT_OFS);
    assign wr_per[0] = wr_en & (paddr == GT_FIRST_PER_OFS);
    assign wr_per[1] = wr_en & (paddr == GT_SECOND_PER_OFS);
    assign wr_per[2] = wr_en & (paddr == GT_THIRD_PER_OFS);
    assign wr_flag   = wr_en & (paddr == GT_FLAG_OFS);

    always_comb begin
        rd_err  = 1'b0;
        rd_data = 32'h0000_0000;
        if (paddr == GT_FIRST_CTL_OFS) begin
            rd_data = {16'h0000, ctl_r[0]};
        end else if (paddr == GT_FIRST_CNT_OFS) begin
            rd_data = {16'h0000, cnt_r[0]};
        end else if (paddr == GT_FIRST_PER_OFS) begin
            rd_data = {16'h0000, per_r[0]};
        end else if (paddr == GT_SECOND_CTL_OFS) begin
            rd_data = {16'h0000, ctl_r[1]};
        end else if (paddr == GT_SECOND_CNT_OFS) begin
            rd_data = {16'h0000, cnt_r[1]};
        end else if (paddr == GT_SECOND_PER_OFS) begin
            rd_data = {16'h0000, per_r[1]};
        end else if (paddr == GT_THIRD_CTL_OFS) begin
            rd_data = {16'h0000, ctl_r[2]};
        end else if (paddr == GT_THIRD_CNT_OFS) begin
            rd_data = {16'h0000, cnt_r[2]};
        end else if (paddr == GT_THIRD_PER_OFS) begin
            rd_data = {16'h0000, per_r[2]};
        end else if (paddr == GT_FLAG_OFS) begin
            rd_data = {29'h0000_0000, flag_r};
        end else begin
            rd_err = 1'b1;
        end
    end

    // decoded controls; third timer's are unused when joined
    assign c[0]   = gt_decode(ctl_r[0]);
    assign c[1]   = gt_decode(ctl_r[1]);
    assign c[2]   = gt_decode(ctl_r[2]);
    assign join_w = c[1].join_w;

    // unsynchronized first-timer path skips the alignment stage only;
    // a true second domain is not modelled, so both paths stay metastable-safe
    assign lvl[0] = c[0].sync ? pin_s3_r[0] : pin_s2_r[0];
    assign lvl[1] = pin_s3_r[1];
    assign lvl[2] = pin_s3_r[2];
    assign rise   = lvl & ~prev_r;
    assign fall   = ~lvl & prev_r;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_tick
            assign gated[g]    = c[g].gate_en & ~c[g].src_ext;
            assign run[g]      = c[g].run
                                 & ~(idle_mode & c[g].halt_idle);
            assign src_tick[g] = run[g] & (c[g].src_ext ? rise[g]
                                 : (~gated[g] | lvl[g]));
            assign pre_hit[g]  = src_tick[g]
                                 & (pre_r[g] == gt_pre_max(c[g].presc));
            assign match16[g]  = cnt_r[g] == per_r[g];
        end
    endgenerate

    assign cnt32     = {cnt_r[2], cnt_r[1]};
    assign per32     = {per_r[2], per_r[1]};
    assign match32   = cnt32 == per32;
    assign cnt32_inc = cnt32 + 32'h0000_0001;

    always_comb begin
        set_flag = 3'h0;
        adc_nxt  = 1'b0;
        for (int i = 0; i < 3; i++) begin
            cnt_nxt[i] = cnt_r[i];
            pre_nxt[i] = src_tick[i] ? (pre_hit[i] ? 8'h00
                         : pre_r[i] + 8'h01) : pre_r[i];
        end
        for (int i = 0; i < 3; i++) begin
            if (!(join_w && i > 0)) begin
                if (pre_hit[i]) begin
                    if (match16[i] && !gated[i]) begin
                        cnt_nxt[i]  = 16'h0000;
                        set_flag[i] = 1'b1;
                    end else begin
                        cnt_nxt[i] = cnt_r[i] + 16'h0001;
                    end
                end
                if (run[i] && gated[i] && fall[i]) begin
                    set_flag[i] = 1'b1;
                end
            end
        end
        if (join_w) begin
            if (pre_hit[1]) begin
                if (match32 && !gated[1]) begin
                    cnt_nxt[1]  = 16'h0000;
                    cnt_nxt[2]  = 16'h0000;
                    set_flag[2] = 1'b1;
                    adc_nxt     = 1'b1;
                end else begin
                    cnt_nxt[1] = cnt32_inc[15:0];
                    cnt_nxt[2] = cnt32_inc[31:16];
                end
            end
            if (run[1] && gated[1] && fall[1]) begin
                set_flag[2] = 1'b1;
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (wr_cnt[i]) begin
                cnt_nxt[i] = wdat;
            end
            if (wr_ctl[i]) begin
                pre_nxt[i] = 8'h00;
            end
        end
    end

    // hardware set wins over a software clear in the same cycle
    assign flag_nxt = (flag_r & ~(wr_flag ? pwdata[2:0] : 3'h0)) | set_flag;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_s3_r <= 3'h0;
            prev_r   <= 3'h0;
        end else begin
            pin_s1_r <= {third_ext_clock_pin, second_ext_clock_pin,
                         first_ext_clock_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            prev_r   <= lvl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= acc;
            pslverr_r <= acc & rd_err;
            prdata_r  <= (acc && !pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                ctl_r[i] <= GT_CTL_RST;
                cnt_r[i] <= GT_CNT_RST;
                per_r[i] <= GT_PER_RST;
                pre_r[i] <= 8'h00;
            end
            flag_r <= 3'h0;
            adc_r  <= 1'b0;
        end else begin
            if (wr_ctl[0]) ctl_r[0] <= wdat & GT_FIRST_CTL_MASK;
            if (wr_ctl[1]) ctl_r[1] <= wdat & GT_SECOND_CTL_MASK;
            if (wr_ctl[2]) ctl_r[2] <= wdat & GT_THIRD_CTL_MASK;
            for (int i = 0; i < 3; i++) begin
                if (wr_per[i]) per_r[i] <= wdat;
                cnt_r[i] <= cnt_nxt[i];
                pre_r[i] <= pre_nxt[i];
            end
            flag_r <= flag_nxt;
            adc_r  <= adc_nxt;
        end
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign first_irq_flag  = flag_r[0];
    assign second_irq_flag = flag_r[1];
    assign third_irq_flag  = flag_r[2];
    assign tb_second_count = cnt_r[1];
    assign tb_third_count  = cnt_r[2];
    assign adc_trigger     = adc_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_first_wrap;
        run[0] && pre_hit[0] && match16[0] && !gated[0] && !wr_cnt[0];
    endsequence

    sequence s_gate_fall;
        run[0] && gated[0] && fall[0];
    endsequence

    a_rsvd_first_zero: assert property (
        (ctl_r[0] & ~GT_FIRST_CTL_MASK) == 16'h0000)
        else $error("reserved first control bits not zero");

    a_stop_holds: assert property (
        !c[0].run && !wr_cnt[0] |=> cnt_r[0] == $past(cnt_r[0]))
        else $error("stopped first timer changed count");

    a_idle_halt: assert property (
        idle_mode && c[0].halt_idle && !wr_cnt[0]
        |=> $stable(cnt_r[0]))
        else $error("first timer counted while halted in idle");

    a_first_wrap: assert property (
        s_first_wrap |=> cnt_r[0] == 16'h0000 && flag_r[0])
        else $error("first timer did not wrap and flag on match");

    a_gate_flag: assert property (
        s_gate_fall |=> flag_r[0])
        else $error("gate fall did not set first flag");

    a_presc_256: assert property (
        c[0].presc == 2'h3 && pre_hit[0] |-> pre_r[0] == 8'hFF)
        else $error("prescale 1:256 terminal count wrong");

    a_internal_step: assert property (
        run[0] && !c[0].src_ext && !gated[0] && c[0].presc == 2'h0
        && !match16[0] && !wr_cnt[0] && !wr_ctl[0]
        |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001)
        else $error("internal clock did not step first count");

    a_join_carry: assert property (
        join_w && pre_hit[1] && !match32 && cnt_r[1] == 16'hFFFF
        && !wr_cnt[1] && !wr_cnt[2]
        |=> cnt_r[1] == 16'h0000
            && cnt_r[2] == $past(cnt_r[2]) + 16'h0001)
        else $error("low word carry did not reach high word");

    a_join_flag: assert property (
        join_w && pre_hit[1] && match32 && !gated[1]
        |=> flag_r[2] && adc_trigger ##1 !adc_trigger)
        else $error("joined match did not flag third timer");

    a_adc_only_join: assert property (
        adc_trigger |-> $past(join_w))
        else $error("converter trigger without joined timer");

    // an external source must not advance without a synced rising edge
    a_gate_ignored: assert property (
        run[0] && c[0].src_ext && !rise[0] && !wr_cnt[0]
        |=> $stable(cnt_r[0]))
        else $error("external source counted without an edge");

    a_split_flag: assert property (
        !join_w && pre_hit[1] && match16[1] && !gated[1]
        |=> flag_r[1])
        else $error("split second timer did not flag on match");

endmodule : gt_timers

// ==== bench/gt_pins_model.sv ====
module gt_pins_model (
    // timing reference
    input  wire logic       pclk,
    // external clock and gate pins
    output logic      [2:0] ext_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // pins rest low between bursts, as a stopped source would
    initial ext_pin = 3'h0;

    task automatic pulses(input int idx, input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge pclk);
            ext_pin[idx] <= 1'b1;
            repeat (half) @(posedge pclk);
            ext_pin[idx] <= 1'b0;
        end
    endtask : pulses

    task automatic gate(input int idx, input int len);
        @(posedge pclk);
        ext_pin[idx] <= 1'b1;
        repeat (len) @(posedge pclk);
        ext_pin[idx] <= 1'b0;
    endtask : gate
endmodule : gt_pins_model

// ==== bench/test_general_timers_16_32bit.sv ====
module test_general_timers_16_32bit
    import gt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idle_mode;
    logic [2:0]  ext_pin;
    logic        first_irq_flag;
    logic        second_irq_flag;
    logic        third_irq_flag;
    logic [15:0] tb_second_count;
    logic [15:0] tb_third_count;
    logic        adc_trigger;
    logic        adc_seen = 1'b0;
    logic [31:0] q;
    logic        e;
    int          err_total;
    int          comparisons;
    int          ratio [4] = '{1, 8, 64, 256};

    gt_timers gt_timers_inst (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .idle_mode            (idle_mode),
        .first_ext_clock_pin  (ext_pin[0]),
        .second_ext_clock_pin (ext_pin[1]),
        .third_ext_clock_pin  (ext_pin[2]),
        .first_irq_flag       (first_irq_flag),
        .second_irq_flag      (second_irq_flag),
        .third_irq_flag       (third_irq_flag),
        .tb_second_count      (tb_second_count),
        .tb_third_count       (tb_third_count),
        .adc_trigger          (adc_trigger)
    );

    gt_pins_model gt_pins_model_inst (
        .pclk    (pclk),
        .ext_pin (ext_pin)
    );

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    // the trigger is a one-cycle pulse, so it is caught here
    always @(posedge pclk) begin
        if (adc_trigger === 1'b1) adc_seen <= 1'b1;
    end

    task automatic conclude();
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk

    task automatic inr(input logic [31:0] got, input int lo, input int hi);
        chk({31'h0, (got >= lo && got <= hi)}, 32'h1);
    endtask : inr

    // starts one edge after the caller, so psel never moves twice at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rq,
                       output logic re);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic        re;
        apb(1'b1, a, d, rq, re);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] rq);
        logic re;
        apb(1'b0, a, 32'h0, rq, re);
    endtask : rd

    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        conclude();
    end

    initial begin
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        idle_mode = 1'b0;
        presetn   = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(GT_FIRST_CTL_OFS, q);
        chk(q, 32'h0);
        rd(GT_FIRST_PER_OFS, q);
        chk(q, 32'h0000FFFF);
        wr(GT_FIRST_CTL_OFS, 32'hFFFFFFFF);
        rd(GT_FIRST_CTL_OFS, q);
        chk(q, 32'h0000A076);
        wr(GT_FIRST_CTL_OFS, 32'h0);
        apb(1'b0, 8'h28, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        // period match with a short period
        wr(GT_FIRST_PER_OFS, 32'h2);
        wr(GT_FIRST_CNT_OFS, 32'h0);
        wr(GT_FLAG_OFS, 32'h7);
        wr(GT_FIRST_CTL_OFS, 32'h8000);
        repeat (20) @(posedge pclk);
        wr(GT_FIRST_CTL_OFS, 32'h0);
        chk({31'h0, first_irq_flag}, 32'h1);
        rd(GT_FLAG_OFS, q);
        chk(q & 32'h1, 32'h1);
        rd(GT_FIRST_CNT_OFS, q);
        inr(q, 0, 2);
        wr(GT_FLAG_OFS, 32'h1);
        rd(GT_FLAG_OFS, q);
        chk(q & 32'h1, 32'h0);
        wr(GT_FIRST_PER_OFS, 32'hFFFF);
        for (int p = 0; p < 4; p++) begin
            wr(GT_FIRST_CNT_OFS, 32'h0);
            wr(GT_FIRST_CTL_OFS, 32'h8000 | (32'(p) << 4));
            repeat (2560) @(posedge pclk);
            wr(GT_FIRST_CTL_OFS, 32'h0);
            rd(GT_FIRST_CNT_OFS, q);
            inr(q, 2560 / ratio[p] - 1, 2568 / ratio[p] + 1);
        end
        idle_mode <= 1'b1;
        wr(GT_FIRST_CNT_OFS, 32'h0);
        wr(GT_FIRST_CTL_OFS, 32'hA000);
        repeat (50) @(posedge pclk);
        wr(GT_FIRST_CTL_OFS, 32'h0);
        rd(GT_FIRST_CNT_OFS, q);
        chk(q, 32'h0);
        wr(GT_FIRST_CTL_OFS, 32'h8000);
        repeat (50) @(posedge pclk);
        wr(GT_FIRST_CTL_OFS, 32'h0);
        rd(GT_FIRST_CNT_OFS, q);
        inr(q, 50, 56);
        idle_mode <= 1'b0;
        // external edges, gate bit set but it must be ignored
        for (int s = 0; s < 2; s++) begin
            wr(GT_FIRST_CNT_OFS, 32'h0);
            wr(GT_FIRST_CTL_OFS, 32'h8042 | (32'(s) << 2));
            gt_pins_model_inst.pulses(0, 5, (s == 1) ? 3 : 7);
            repeat (10) @(posedge pclk);
            wr(GT_FIRST_CTL_OFS, 32'h0);
            rd(GT_FIRST_CNT_OFS, q);
            chk(q, 32'h5);
        end
        wr(GT_FLAG_OFS, 32'h7);
        wr(GT_FIRST_CNT_OFS, 32'h0);
        wr(GT_FIRST_CTL_OFS, 32'h8040);
        gt_pins_model_inst.gate(0, 40);
        repeat (10) @(posedge pclk);
        wr(GT_FIRST_CTL_OFS, 32'h0);
        rd(GT_FIRST_CNT_OFS, q);
        inr(q, 38, 44);
        rd(GT_FLAG_OFS, q);
        chk(q & 32'h1, 32'h1);
        // joined pair; third control set running, which the join must ignore
        wr(GT_FLAG_OFS, 32'h7);
        wr(GT_SECOND_CTL_OFS, 32'h0008);
        wr(GT_THIRD_CTL_OFS, 32'h8000);
        wr(GT_SECOND_PER_OFS, 32'h2);
        wr(GT_THIRD_PER_OFS, 32'h1);
        wr(GT_SECOND_CNT_OFS, 32'hFFFE);
        wr(GT_THIRD_CNT_OFS, 32'h0);
        wr(GT_SECOND_CTL_OFS, 32'h8008);
        wr(GT_SECOND_CTL_OFS, 32'h0008);
        rd(GT_THIRD_CNT_OFS, q);
        chk(q, 32'h1);
        rd(GT_SECOND_CNT_OFS, q);
        inr(q, 0, 2);
        inr({tb_third_count, tb_second_count}, 65536, 65538);
        wr(GT_SECOND_CTL_OFS, 32'h8008);
        repeat (20) @(posedge pclk);
        wr(GT_THIRD_CTL_OFS, 32'h0);
        wr(GT_SECOND_CTL_OFS, 32'h0);
        rd(GT_FLAG_OFS, q);
        chk(q & 32'h6, 32'h4);
        chk({31'h0, third_irq_flag}, 32'h1);
        chk({31'h0, adc_seen}, 32'h1);
        // split again: the second timer flags for itself
        wr(GT_FLAG_OFS, 32'h7);
        wr(GT_SECOND_CNT_OFS, 32'h0);
        wr(GT_THIRD_CNT_OFS, 32'h0);
        wr(GT_SECOND_CTL_OFS, 32'h8000);
        repeat (20) @(posedge pclk);
        wr(GT_SECOND_CTL_OFS, 32'h0);
        rd(GT_FLAG_OFS, q);
        chk(q & 32'h6, 32'h2);
        chk({31'h0, second_irq_flag}, 32'h1);
        rd(GT_THIRD_CNT_OFS, q);
        chk(q, 32'h0);
        conclude();
    end
endmodule : test_general_timers_16_32bit
